// ### logic/sysref_divider_control.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
// Function
// - power-down bit 0 keeps sysref blocks up, 1 powers them down.
// - power-down also stops the frequency divider and idles the bias outputs.
// - four cascaded stages; top 2/4, middle fields 2/4/8/16.
// - total ratio is the product of the four stage ratios.
// - lowest stage code 10 divides by 4, code 11 by 5.
// - lowest stage code 01 divides by 3; 0,01,11,01 gives 384.
// - bias type 0: output static low/high while forced or in event.
// - bias type 1: output cross-point biased while forced or in event.
// - after reset power-down reads 0, divider field 0101111.
module sysref_divider_control (
   input wire logic clk,
   input wire logic rst,
   input wire logic [sysref_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sysref_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [sysref_pkg::NUM_OUT-1:0] per_output_bias_force,
   input wire logic sysref_event,
   output logic sysref_blocks_powered_down,
   output logic sysref_div_pulse,
   output logic [sysref_pkg::NUM_OUT-1:0] sysref_output_r_static,
   output logic [sysref_pkg::NUM_OUT-1:0] sysref_output_r_xpoint
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [7:0] power_div_q, power_div_d;
   logic [7:0] bias_rel_q, bias_rel_d;
   logic [7:0] pulse_cnt_q, pulse_cnt_d;
   logic [7:0] global_dly_q, global_dly_d;
   logic [7:0] gen_ctl_q, gen_ctl_d;
   logic [7:0] aux_ctl_q, aux_ctl_d;

   logic aw_held_q, aw_held_d;
   logic [sysref_pkg::ADDR_W-1:0] aw_addr_q, aw_addr_d;
   logic w_held_q, w_held_d;
   logic [7:0] w_data_q, w_data_d;
   logic w_lane_q, w_lane_d;
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic wr_commit;
   logic wr_hit;

   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;

   logic pd_q, pd_d;
   logic [sysref_pkg::NUM_OUT-1:0] out_static_q, out_static_d;
   logic [sysref_pkg::NUM_OUT-1:0] out_xpoint_q, out_xpoint_d;

   sysref_div_if div_link ();

   // ----------------------------------------------------------------
   // port drive, all from flops
   // ----------------------------------------------------------------
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign sysref_blocks_powered_down = pd_q;
   assign sysref_div_pulse = div_link.pulse;
   assign sysref_output_r_static = out_static_q;
   assign sysref_output_r_xpoint = out_xpoint_q;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // word-aligned match on one of the mapped registers
   function automatic logic addr_mapped(input logic [sysref_pkg::ADDR_W-1:0] a,
                                        input logic writable);
      logic hit;
      hit = 1'b0;
      case (a)
         sysref_pkg::ADDR_POWER_DIV,
         sysref_pkg::ADDR_BIAS_REL,
         sysref_pkg::ADDR_PULSE_CNT,
         sysref_pkg::ADDR_GLOBAL_DLY,
         sysref_pkg::ADDR_GEN_CTL,
         sysref_pkg::ADDR_AUX_CTL: hit = 1'b1;
         sysref_pkg::ADDR_STATUS: hit = !writable;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   assign wr_commit = aw_held_q && w_held_q && !bvalid_q;
   assign wr_hit = addr_mapped(aw_addr_q, 1'b1);

   // address and data are caught in either order; the answer waits
   // for both, and neither is accepted again until it is taken
   always_comb begin
      aw_held_d = aw_held_q;
      aw_addr_d = aw_addr_q;
      w_held_d = w_held_q;
      w_data_d = w_data_q;
      w_lane_d = w_lane_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (s_axi_awvalid && awready_q) begin
         aw_held_d = 1'b1;
         aw_addr_d = {s_axi_awaddr[sysref_pkg::ADDR_W-1:2], 2'h0};
      end
      if (s_axi_wvalid && wready_q) begin
         w_held_d = 1'b1;
         w_data_d = s_axi_wdata[7:0];
         w_lane_d = s_axi_wstrb[0];
      end
      if (wr_commit) begin
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_hit ? sysref_pkg::RESP_OKAY : sysref_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      awready_d = !aw_held_d && !bvalid_d;
      wready_d = !w_held_d && !bvalid_d;
   end

   // write channel registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
         w_held_q <= 1'b0;
         w_data_q <= 8'h00;
         w_lane_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= sysref_pkg::RESP_OKAY;
      end else begin
         aw_held_q <= aw_held_d;
         aw_addr_q <= aw_addr_d;
         w_held_q <= w_held_d;
         w_data_q <= w_data_d;
         w_lane_q <= w_lane_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // only byte lane 0 carries data; reserved bits are never stored
   always_comb begin
      power_div_d = power_div_q;
      bias_rel_d = bias_rel_q;
      pulse_cnt_d = pulse_cnt_q;
      global_dly_d = global_dly_q;
      gen_ctl_d = gen_ctl_q;
      aux_ctl_d = aux_ctl_q;
      if (wr_commit && w_lane_q) begin
         case (aw_addr_q)
            sysref_pkg::ADDR_POWER_DIV: power_div_d = w_data_q;
            sysref_pkg::ADDR_BIAS_REL: bias_rel_d = w_data_q;
            sysref_pkg::ADDR_PULSE_CNT: pulse_cnt_d = w_data_q;
            sysref_pkg::ADDR_GLOBAL_DLY: global_dly_d = w_data_q;
            sysref_pkg::ADDR_GEN_CTL: gen_ctl_d = w_data_q & sysref_pkg::GEN_CTL_MASK;
            sysref_pkg::ADDR_AUX_CTL: aux_ctl_d = w_data_q & sysref_pkg::AUX_CTL_MASK;
            default: power_div_d = power_div_q;
         endcase
      end
   end

   // configuration storage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_div_q <= sysref_pkg::RST_POWER_DIV;
         bias_rel_q <= sysref_pkg::RST_BIAS_REL;
         pulse_cnt_q <= sysref_pkg::RST_PULSE_CNT;
         global_dly_q <= sysref_pkg::RST_GLOBAL_DLY;
         gen_ctl_q <= sysref_pkg::RST_GEN_CTL;
         aux_ctl_q <= sysref_pkg::RST_AUX_CTL;
      end else begin
         power_div_q <= power_div_d;
         bias_rel_q <= bias_rel_d;
         pulse_cnt_q <= pulse_cnt_d;
         global_dly_q <= global_dly_d;
         gen_ctl_q <= gen_ctl_d;
         aux_ctl_q <= aux_ctl_d;
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   // one read at a time: arready drops while the answer is pending
   always_comb begin
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = addr_mapped({s_axi_araddr[sysref_pkg::ADDR_W-1:2], 2'h0}, 1'b0) ?
            sysref_pkg::RESP_OKAY : sysref_pkg::RESP_SLVERR;
         case ({s_axi_araddr[sysref_pkg::ADDR_W-1:2], 2'h0})
            sysref_pkg::ADDR_POWER_DIV: rdata_d = {24'h0, power_div_q};
            sysref_pkg::ADDR_BIAS_REL: rdata_d = {24'h0, bias_rel_q};
            sysref_pkg::ADDR_PULSE_CNT: rdata_d = {24'h0, pulse_cnt_q};
            sysref_pkg::ADDR_GLOBAL_DLY: rdata_d = {24'h0, global_dly_q};
            sysref_pkg::ADDR_GEN_CTL: rdata_d = {24'h0, gen_ctl_q};
            sysref_pkg::ADDR_AUX_CTL: rdata_d = {24'h0, aux_ctl_q};
            sysref_pkg::ADDR_STATUS: begin
               rdata_d = {18'h0, pd_q, sysref_pkg::ratio_total(power_div_q[6:0])};
            end
            default: rdata_d = 32'h0000_0000;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      arready_d = !rvalid_d;
   end

   // read channel registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= sysref_pkg::RESP_OKAY;
      end else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // ----------------------------------------------------------------
   // power-down and divider hookup
   // ----------------------------------------------------------------
   // divider ratios are picked by software; it is expected to favour the
   // low stage when several codes give one ratio, the logic cares not
   assign div_link.run = !pd_q;
   assign div_link.code = power_div_q[6:0];

   sysref_stage_divider u_div (
      .clk(clk),
      .rst(rst),
      .dv(div_link)
   );

   // ----------------------------------------------------------------
   // output bias selection
   // ----------------------------------------------------------------
   // a forced or event output takes static or cross-point bias by type;
   // outputs of a powered-down path fall idle in neither state
   always_comb begin
      pd_d = power_div_q[sysref_pkg::POWERDOWN_BIT];
      for (int i = 0; i < sysref_pkg::NUM_OUT; i++) begin
         out_static_d[i] = !pd_d && (per_output_bias_force[i] || sysref_event)
            && !bias_rel_q[sysref_pkg::BIAS_TYPE_BIT];
         out_xpoint_d[i] = !pd_d && (per_output_bias_force[i] || sysref_event)
            && bias_rel_q[sysref_pkg::BIAS_TYPE_BIT];
      end
   end

   // bias and power state registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pd_q <= 1'b0;
         out_static_q <= '0;
         out_xpoint_q <= '0;
      end else begin
         pd_q <= pd_d;
         out_static_q <= out_static_d;
         out_xpoint_q <= out_xpoint_d;
      end
   end

endmodule

// ### logic/sysref_pkg.sv
package sysref_pkg;

   // ----------------------------------------------------------------
   // register indices and byte addresses (address = index times four)
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam logic [7:0] IDX_POWER_DIV = 8'h18;
   localparam logic [7:0] IDX_BIAS_REL = 8'h19;
   localparam logic [7:0] IDX_PULSE_CNT = 8'h1A;
   localparam logic [7:0] IDX_GLOBAL_DLY = 8'h1B;
   localparam logic [7:0] IDX_GEN_CTL = 8'h1C;
   localparam logic [7:0] IDX_STATUS = 8'h1D;
   localparam logic [7:0] IDX_AUX_CTL = 8'h70;
   localparam logic [ADDR_W-1:0] ADDR_POWER_DIV = {2'h0, IDX_POWER_DIV, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_BIAS_REL = {2'h0, IDX_BIAS_REL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_PULSE_CNT = {2'h0, IDX_PULSE_CNT, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_GLOBAL_DLY = {2'h0, IDX_GLOBAL_DLY, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_GEN_CTL = {2'h0, IDX_GEN_CTL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_AUX_CTL = {2'h0, IDX_AUX_CTL, 2'h0};

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned POWERDOWN_BIT = 7;
   localparam int unsigned BIAS_TYPE_BIT = 7;
   localparam int unsigned AUX_BIT = 7;
   localparam int unsigned STATUS_PD_BIT = 13;
   localparam logic [7:0] GEN_CTL_MASK = 8'h03;
   localparam logic [7:0] AUX_CTL_MASK = 8'h80;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_POWER_DIV = 8'h2F;
   localparam logic [7:0] RST_BIAS_REL = 8'h81;
   localparam logic [7:0] RST_PULSE_CNT = 8'h02;
   localparam logic [7:0] RST_GLOBAL_DLY = 8'h00;
   localparam logic [7:0] RST_GEN_CTL = 8'h00;
   localparam logic [7:0] RST_AUX_CTL = 8'h00;

   // ----------------------------------------------------------------
   // sizes and bus answers
   // ----------------------------------------------------------------
   localparam int unsigned NUM_OUT = 8;
   localparam int unsigned STAGE_W = 5;
   localparam int unsigned RATIO_W = 13;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // divider stage decode
   // ----------------------------------------------------------------
   // top stage: 0 gives 2, 1 gives 4
   function automatic logic [STAGE_W-1:0] ratio_top(input logic code);
      return code ? 5'h04 : 5'h02;
   endfunction

   // middle stages: 2, 4, 8, 16
   function automatic logic [STAGE_W-1:0] ratio_mid(input logic [1:0] code);
      return 5'(5'h02 << code);
   endfunction

   // lowest stage: 2, 3, 4, 5
   function automatic logic [STAGE_W-1:0] ratio_low(input logic [1:0] code);
      return 5'(5'h02 + {3'h0, code});
   endfunction

   // overall ratio is the product of the four stages
   function automatic logic [RATIO_W-1:0] ratio_total(input logic [6:0] ns);
      logic [19:0] p;
      p = 20'(ratio_top(ns[6])) * 20'(ratio_mid(ns[5:4]))
         * 20'(ratio_mid(ns[3:2])) * 20'(ratio_low(ns[1:0]));
      return p[RATIO_W-1:0];
   endfunction

endpackage

// ### logic/sysref_div_if.sv
`timescale 1ns/10ps
// settings toward the divider and its output pulse back
interface sysref_div_if;
   logic run;
   logic [6:0] code;
   logic pulse;
   modport ctl (output run, output code, input pulse);
   modport div (input run, input code, output pulse);
endinterface

// ### logic/sysref_stage_divider.sv
`timescale 1ns/10ps
module sysref_stage_divider (
   input wire logic clk,
   input wire logic rst,
   sysref_div_if.div dv
);

   // ----------------------------------------------------------------
   // four cascaded stage counters
   // ----------------------------------------------------------------
   logic [sysref_pkg::STAGE_W-1:0] cnt_q [4];
   logic [sysref_pkg::STAGE_W-1:0] cnt_d [4];
   logic [sysref_pkg::STAGE_W-1:0] lim [4];
   logic pulse_q;
   logic pulse_d;

   assign dv.pulse = pulse_q;

   // each stage advances when all lower stages wrap; >= keeps a live
   // code change from stranding a counter above its new limit
   always_comb begin
      logic carry;
      carry = 1'b1;
      lim[0] = sysref_pkg::ratio_low(dv.code[1:0]);
      lim[1] = sysref_pkg::ratio_mid(dv.code[3:2]);
      lim[2] = sysref_pkg::ratio_mid(dv.code[5:4]);
      lim[3] = sysref_pkg::ratio_top(dv.code[6]);
      for (int i = 0; i < 4; i++) begin
         cnt_d[i] = cnt_q[i];
         if (carry) begin
            if (cnt_q[i] >= 5'(lim[i] - 5'h01)) begin
               cnt_d[i] = '0;
            end else begin
               cnt_d[i] = 5'(cnt_q[i] + 5'h01);
               carry = 1'b0;
            end
         end
      end
      pulse_d = carry;
      // powered down: counters parked, no output
      if (!dv.run) begin
         for (int i = 0; i < 4; i++) begin
            cnt_d[i] = '0;
         end
         pulse_d = 1'b0;
      end
   end

   // registers only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            cnt_q[i] <= '0;
         end
         pulse_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pulse_q <= pulse_d;
      end
   end

endmodule

// ### bench/sysref_converter_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// converter side: counts sysref pulses and the cycles between them
// ----------------------------------------------------------------
module sysref_converter_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic sysref_div_pulse,
   output int pulse_cnt,
   output int last_gap
);
   int since_q;
   // gap is counted in clock cycles, the first gap after a change may be partial
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pulse_cnt <= 0;
         last_gap <= 0;
         since_q <= 0;
      end else if (sysref_div_pulse === 1'b1) begin
         pulse_cnt <= pulse_cnt + 1;
         last_gap <= since_q + 1;
         since_q <= 0;
      end else begin
         since_q <= since_q + 1;
      end
   end
endmodule

// ### bench/sysref_divider_control_sva.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port checker for the sysref control block
// ----------------------------------------------------------------
module sysref_divider_control_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [sysref_pkg::NUM_OUT-1:0] per_output_bias_force,
   input wire logic sysref_event,
   input wire logic sysref_blocks_powered_down,
   input wire logic sysref_div_pulse,
   input wire logic [sysref_pkg::NUM_OUT-1:0] sysref_output_r_static,
   input wire logic [sysref_pkg::NUM_OUT-1:0] sysref_output_r_xpoint
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // the smallest ratio is 16, so a pulse is followed by at least 8 quiet cycles
   a_pulse_stays_single: assert property (sysref_div_pulse |=> !sysref_div_pulse [*8])
      else $error("divider pulses too close together");
   // one cycle of grace: the pulse flop sees the bit a cycle after its copy does
   a_pd_stops_divider: assert property (sysref_blocks_powered_down &&
      $past(sysref_blocks_powered_down) |-> !sysref_div_pulse)
      else $error("divider pulse while powered down");
   a_pd_bias_off: assert property (sysref_blocks_powered_down &&
      $past(sysref_blocks_powered_down) |-> (sysref_output_r_static | sysref_output_r_xpoint) == '0)
      else $error("bias output active while powered down");
   a_bias_kind_exclusive: assert property ((sysref_output_r_static & sysref_output_r_xpoint) == '0)
      else $error("output in both bias states");
   a_bias_follows_force: assert property (!sysref_blocks_powered_down &&
      !$past(sysref_blocks_powered_down) && !$past(sysref_blocks_powered_down, 2) |->
      (sysref_output_r_static | sysref_output_r_xpoint) ==
      $past(per_output_bias_force | {sysref_pkg::NUM_OUT{sysref_event}}))
      else $error("bias outputs do not follow force and event");
   a_write_gets_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_bresp_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response held after handshake");
   a_read_gets_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_read_one_open: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("new read taken while data pending");
endmodule
bind sysref_divider_control sysref_divider_control_sva sva_u (.clk, .rst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .per_output_bias_force, .sysref_event,
   .sysref_blocks_powered_down, .sysref_div_pulse, .sysref_output_r_static,
   .sysref_output_r_xpoint);

// ### bench/sysref_divider_control_tb_top.sv
`timescale 1ns/10ps
module sysref_divider_control_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [sysref_pkg::ADDR_W-1:0] s_axi_awaddr = '0;
   logic [sysref_pkg::ADDR_W-1:0] s_axi_araddr = '0;
   logic [2:0] s_axi_awprot = 3'h0;
   logic [2:0] s_axi_arprot = 3'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sysref_event = 1'b0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [7:0] per_output_bias_force = 8'h00;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic sysref_blocks_powered_down, sysref_div_pulse;
   logic [7:0] sysref_output_r_static, sysref_output_r_xpoint;
   int pulse_cnt, last_gap;
   int miscompares = 0, checks_done = 0, cyc = 0;
   logic [7:0] mdl [int unsigned];
   logic [11:0] addrs[6] = '{sysref_pkg::ADDR_POWER_DIV, sysref_pkg::ADDR_BIAS_REL,
      sysref_pkg::ADDR_PULSE_CNT, sysref_pkg::ADDR_GLOBAL_DLY, sysref_pkg::ADDR_GEN_CTL,
      sysref_pkg::ADDR_AUX_CTL};
   logic [7:0] rstv[6] = '{8'h2F, 8'h81, 8'h02, 8'h00, 8'h00, 8'h00};
   // 0x1D gives 384 with the lower middle stage as high as it can go
   logic [6:0] codes[4] = '{7'h1D, 7'h00, 7'h03, 7'h02};

   sysref_divider_control dut_u (.clk, .rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .per_output_bias_force, .sysref_event, .sysref_blocks_powered_down, .sysref_div_pulse,
      .sysref_output_r_static, .sysref_output_r_xpoint);
   sysref_converter_model model_u (.clk, .rst, .sysref_div_pulse, .pulse_cnt, .last_gap);

   // ----------------------------------------------------------------
   // clock, timeout and closing report
   // ----------------------------------------------------------------
   always #2 clk = ~clk;
   // ceiling far above the sequence length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         miscompares++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ----------------------------------------------------------------
   // bus master tasks and reference model
   // ----------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] st,
                     output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_bvalid === 1'b1) break;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_rvalid === 1'b1) break;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   function automatic int ratio_of(input logic [6:0] ns);
      return (ns[6] ? 4 : 2) * (2 << ns[5:4]) * (2 << ns[3:2]) * (2 + ns[1:0]);
   endfunction

   // reserved bits are not stored
   function automatic logic [7:0] wmask(input logic [11:0] a);
      return a == sysref_pkg::ADDR_GEN_CTL ? sysref_pkg::GEN_CTL_MASK :
         a == sysref_pkg::ADDR_AUX_CTL ? sysref_pkg::AUX_CTL_MASK : 8'hFF;
   endfunction

   // limit keeps a dead divider from hanging the run
   task automatic wait_pulses(input int n);
      int start, k;
      start = pulse_cnt;
      k = 0;
      while (pulse_cnt < start + n && k < 20000) begin
         @(posedge clk);
         k++;
      end
      chk(k < 20000, 1'b1);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] v, m;
      int n;
      void'($urandom(32'hA8AD));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      foreach (addrs[i]) begin
         mdl[addrs[i]] = rstv[i];
         rd(addrs[i], d, r);
         chk(d, {24'h0, rstv[i]});
      end
      rd(sysref_pkg::ADDR_STATUS, d, r);
      chk(d, 32'h0000_0500);
      // unmapped, read-only and strobe-less accesses
      rd(12'h004, d, r);
      chk(d, 32'h0000_0000);
      chk(r, sysref_pkg::RESP_SLVERR);
      wr(12'h004, 8'h55, 4'hF, r);
      chk(r, sysref_pkg::RESP_SLVERR);
      wr(sysref_pkg::ADDR_STATUS, 8'h55, 4'hF, r);
      chk(r, sysref_pkg::RESP_SLVERR);
      wr(sysref_pkg::ADDR_PULSE_CNT, 8'hA5, 4'h0, r);
      chk(r, sysref_pkg::RESP_OKAY);
      rd(sysref_pkg::ADDR_PULSE_CNT, d, r);
      chk(d, {24'h0, mdl[sysref_pkg::ADDR_PULSE_CNT]});
      foreach (addrs[i]) begin
         v = 8'($urandom);
         mdl[addrs[i]] = v & wmask(addrs[i]);
         wr(addrs[i], v, 4'hF, r);
         chk(r, sysref_pkg::RESP_OKAY);
         rd(addrs[i], d, r);
         chk(d, {24'h0, mdl[addrs[i]]});
         chk(r, sysref_pkg::RESP_OKAY);
      end
      // every divider code against the product of its stages
      for (int c = 0; c < 128; c++) begin
         wr(sysref_pkg::ADDR_POWER_DIV, {1'b0, 7'(c)}, 4'hF, r);
         rd(sysref_pkg::ADDR_STATUS, d, r);
         chk(d, {19'h0, 13'(ratio_of(7'(c)))});
      end
      // second pulse gap after each code change
      foreach (codes[i]) begin
         wr(sysref_pkg::ADDR_POWER_DIV, {1'b0, codes[i]}, 4'hF, r);
         wait_pulses(2);
         chk(last_gap, ratio_of(codes[i]));
      end
      // both bias kinds with random force and event
      for (int bt = 0; bt < 2; bt++) begin
         wr(sysref_pkg::ADDR_BIAS_REL, {bt[0], 7'h01}, 4'hF, r);
         repeat (6) begin
            @(posedge clk);
            per_output_bias_force <= 8'($urandom);
            sysref_event <= 1'($urandom);
            repeat (3) @(posedge clk);
            @(negedge clk);
            m = per_output_bias_force | {8{sysref_event}};
            chk(sysref_output_r_static, bt ? 8'h00 : m);
            chk(sysref_output_r_xpoint, bt ? m : 8'h00);
         end
      end
      // power-down silences all, release restarts
      @(posedge clk);
      per_output_bias_force <= 8'hFF;
      wr(sysref_pkg::ADDR_POWER_DIV, 8'h80, 4'hF, r);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(sysref_blocks_powered_down, 1'b1);
      chk(sysref_output_r_static | sysref_output_r_xpoint, 8'h00);
      n = pulse_cnt;
      repeat (100) @(posedge clk);
      chk(pulse_cnt, n);
      rd(sysref_pkg::ADDR_STATUS, d, r);
      chk(d, 32'h0000_2010);
      wr(sysref_pkg::ADDR_POWER_DIV, 8'h00, 4'hF, r);
      wait_pulses(2);
      chk(last_gap, 16);
      chk(sysref_blocks_powered_down, 1'b0);
      stop_test();
   end
endmodule
